// File: hw/mcl_pkg.sv
// Purpose: constants and types shared by the manchester channel logic
// Assumes: 100 MHz system clock, 10 Mbps line rate
// Notes:   cycle counts other than PIPE_CYC derive from times in ns and the clock period
package mcl_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS   = 100;
    localparam int EDGE_WIN_NS   = 160;
    localparam int FRAME_WAIT_NS = 800;

    localparam int CELL_CYC  = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int HALF_CYC  = CELL_CYC / 2;
    // sync (2) + window flop + output flag flop eat into the 160 ns budget
    localparam int PIPE_CYC  = 4;
    localparam int WIN_CYC   = EDGE_WIN_NS / CLK_PERIOD_NS - PIPE_CYC;
    // least time: round up
    localparam int WAIT_CYC  = (FRAME_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // edge later than 3/4 cell after a mid-cell edge is the next mid-cell edge
    localparam int MID_MIN_CYC = (CELL_CYC * 3 + 3) / 4;

    localparam logic [3:0] CELL_LAST = 4'(CELL_CYC - 1);
    localparam logic [3:0] HALF_POS  = 4'(HALF_CYC);
    localparam logic [3:0] WIN_LOAD  = 4'(WIN_CYC);
    localparam logic [3:0] MID_MIN   = 4'(MID_MIN_CYC);
    localparam logic [3:0] SINCE_MAX = 4'hF;
    localparam logic [6:0] WAIT_LOAD = 7'(WAIT_CYC);

    // ************************************************************
    // preamble
    // ************************************************************
    localparam int          PRE_LEN  = 64;
    localparam logic [63:0] PRE_PAT  = 64'hAAAA_AAAA_AAAA_AAAB;
    localparam logic [5:0]  PRE_LAST = 6'(PRE_LEN - 1);

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        MCL_TX_IDLE = 2'h0,
        MCL_TX_PRE  = 2'h1,
        MCL_TX_DATA = 2'h2
    } mcl_tx_e;

    typedef enum logic [2:0] {
        MCL_FR_WAIT = 3'h0,
        MCL_FR_HOLD = 3'h1,
        MCL_FR_HUNT = 3'h2,
        MCL_FR_PASS = 3'h3,
        MCL_FR_DROP = 3'h4
    } mcl_fr_e;

    // one received bit towards the data link
    typedef struct packed {
        logic stb;
        logic data;
    } mcl_rxbit_s;

endpackage

// File: hw/mcl_channel.sv
// Purpose: manchester encoder with preamble, decoder, collision and
//          activity indications, receive framing
// Assumes: line inputs are asynchronous; data link runs on clk_i
// Notes:   transmit bits pass a two-entry buffer; its ready stalls the link
`timescale 1ns/1ps
`default_nettype none

// Operation
// - manchester cells of 100 ns each
// - inverse bit first half, true bit second
// - first bit coded, no submitted bit lost
// - decoded output within 8 bit cells
// - tolerate partial first bit at start
// - decoder output may be garbage during collision
// - preamble before first data bit
// - 64-bit preamble ending 10101011, left first
// - collision during preamble skips remaining preamble
// - collision indication within 200 ns
// - collision indication only while transmitting
// - collision indication drops within 160 ns
// - activity flag for any station transmitting
// - activity flag within 200 ns
// - activity flag drops 160 ns after both gone
// - receive activity is retriggerable 160 ns window
// - wait 8 bit times before hunting marker
// - after double one forward decoded bits
// - double zero drops the whole frame
// - no extra bits after frame end
module mcl_channel #(
    parameter int BUF_DEPTH = 2                    // transmit buffer entries
) (
    input  wire logic              clk_i,          // 100 MHz system clock
    input  wire logic              sys_rst_i,      // async reset, active high
    input  wire logic              tx_valid_i,     // data link offers a bit
    input  wire logic              tx_data_i,      // offered bit
    output var  logic              tx_ready_o,     // buffer can take a bit
    output var  logic              tx_line_o,      // encoded transmit pair
    output var  logic              tx_en_o,        // encoder is sending
    input  wire logic              rx_line_i,      // receive pair, async
    input  wire logic              col_pres_i,     // collision pair, async
    output var  mcl_pkg::mcl_rxbit_s rx_bit_o,     // forwarded bit and strobe
    output var  logic              rx_frame_o,     // bits are being forwarded
    output var  logic              collision_indication_o, // to data link
    output var  logic              line_activity_flag_o    // to data link
);
    import mcl_pkg::*;

    // ************************************************************
    // input synchronisers and edge detection
    // ************************************************************
    logic [2:0] rx_sync_q;
    logic [2:0] col_sync_q;
    logic       rx_edge;
    logic       col_edge;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_sync_q  <= 3'h0;
            col_sync_q <= 3'h0;
        end else begin
            rx_sync_q  <= {rx_sync_q[1:0], rx_line_i};
            col_sync_q <= {col_sync_q[1:0], col_pres_i};
        end
    end

    // stage 0 is only read by stage 1
    assign rx_edge  = rx_sync_q[2] ^ rx_sync_q[1];
    assign col_edge = col_sync_q[2] ^ col_sync_q[1];

    // ************************************************************
    // retriggerable edge windows
    // ************************************************************
    logic [3:0] rx_win_q;
    logic [3:0] col_win_q;
    logic       rx_act;
    logic       col_act;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_win_q  <= 4'h0;
            col_win_q <= 4'h0;
        end else begin
            if (rx_edge) begin
                rx_win_q <= WIN_LOAD;
            end else if (rx_win_q != 4'h0) begin
                rx_win_q <= rx_win_q - 4'h1;
            end
            // a 10 MHz +-15% waveform edges every 6 cycles at most
            if (col_edge) begin
                col_win_q <= WIN_LOAD;
            end else if (col_win_q != 4'h0) begin
                col_win_q <= col_win_q - 4'h1;
            end
        end
    end

    assign rx_act  = (rx_win_q != 4'h0);
    assign col_act = (col_win_q != 4'h0);

    // ************************************************************
    // transmit buffer
    // ************************************************************
    logic [BUF_DEPTH-1:0] buf_mem_q;
    logic [$clog2(BUF_DEPTH)-1:0] wr_ptr_q;
    logic [$clog2(BUF_DEPTH)-1:0] rd_ptr_q;
    logic [$clog2(BUF_DEPTH):0]   cnt_q;
    logic [$clog2(BUF_DEPTH):0]   cnt_d;
    logic push;
    logic pop;
    logic buf_empty;

    assign push      = tx_valid_i & tx_ready_o;
    assign buf_empty = (cnt_q == '0);

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            buf_mem_q  <= '0;
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            cnt_q      <= '0;
            tx_ready_o <= 1'b0;
        end else begin
            if (push) begin
                buf_mem_q[wr_ptr_q] <= tx_data_i;
                wr_ptr_q <= (wr_ptr_q == ($clog2(BUF_DEPTH))'(BUF_DEPTH - 1)) ?
                            '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == ($clog2(BUF_DEPTH))'(BUF_DEPTH - 1)) ?
                            '0 : rd_ptr_q + 1'b1;
            end
            cnt_q      <= cnt_d;
            // registered ready: never over-fills since it reflects cnt_d
            tx_ready_o <= (cnt_d != ($clog2(BUF_DEPTH)+1)'(BUF_DEPTH));
        end
    end

    // ************************************************************
    // encoder and preamble
    // ************************************************************
    mcl_tx_e    tx_st_q;
    logic [3:0] phase_q;
    logic [5:0] pre_idx_q;
    logic       cur_bit_q;
    logic       cell_end;

    assign cell_end = (phase_q == CELL_LAST);
    // a bit leaves the buffer only at the start of a data cell
    assign pop = !buf_empty &&
                 ((tx_st_q == MCL_TX_IDLE) ? 1'b0 :
                  (cell_end && (tx_st_q == MCL_TX_DATA ||
                   pre_idx_q == 6'h0 || collision_indication_o)));

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_st_q   <= MCL_TX_IDLE;
            phase_q   <= 4'h0;
            pre_idx_q <= 6'h0;
            cur_bit_q <= 1'b0;
        end else begin
            case (tx_st_q)
                MCL_TX_IDLE: begin
                    phase_q <= 4'h0;
                    if (!buf_empty) begin
                        tx_st_q   <= MCL_TX_PRE;
                        pre_idx_q <= PRE_LAST;
                        cur_bit_q <= PRE_PAT[PRE_LAST];
                    end
                end
                MCL_TX_PRE: begin
                    phase_q <= cell_end ? 4'h0 : phase_q + 4'h1;
                    if (cell_end) begin
                        // jump waits for the cell end so no cell is cut short
                        if (pre_idx_q == 6'h0 || collision_indication_o) begin
                            tx_st_q   <= buf_empty ? MCL_TX_IDLE : MCL_TX_DATA;
                            cur_bit_q <= buf_mem_q[rd_ptr_q];
                        end else begin
                            pre_idx_q <= pre_idx_q - 6'h1;
                            cur_bit_q <= PRE_PAT[pre_idx_q - 6'h1];
                        end
                    end
                end
                MCL_TX_DATA: begin
                    // a dry buffer at a cell end closes the frame; the link must keep up
                    phase_q <= cell_end ? 4'h0 : phase_q + 4'h1;
                    if (cell_end) begin
                        tx_st_q   <= buf_empty ? MCL_TX_IDLE : MCL_TX_DATA;
                        cur_bit_q <= buf_mem_q[rd_ptr_q];
                    end
                end
                default: begin
                    tx_st_q <= MCL_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_line_o <= 1'b0;
            tx_en_o   <= 1'b0;
        end else begin
            tx_en_o <= (tx_st_q != MCL_TX_IDLE);
            if (tx_st_q == MCL_TX_IDLE) begin
                tx_line_o <= 1'b0;
            end else begin
                tx_line_o <= (phase_q < HALF_POS) ? ~cur_bit_q : cur_bit_q;
            end
        end
    end

    // ************************************************************
    // collision and activity indications
    // ************************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            collision_indication_o <= 1'b0;
            line_activity_flag_o   <= 1'b0;
        end else begin
            // transmitting means the encoder is not idle, preamble included
            collision_indication_o <= col_act && (tx_st_q != MCL_TX_IDLE);
            line_activity_flag_o   <= rx_act || col_act;
        end
    end

    // ************************************************************
    // decoder
    // ************************************************************
    logic [3:0] since_q;
    logic       dec_stb_q;
    logic       dec_bit_q;
    logic       mid_edge;

    // saturated counter treats the very first edge as mid-cell; a wrong
    // guess costs one bit, which framing never looks at
    assign mid_edge = rx_edge && (since_q >= MID_MIN);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            since_q   <= SINCE_MAX;
            dec_stb_q <= 1'b0;
            dec_bit_q <= 1'b0;
        end else begin
            dec_stb_q <= mid_edge;
            if (mid_edge) begin
                since_q   <= 4'h0;
                dec_bit_q <= rx_sync_q[1];
            end else if (since_q != SINCE_MAX) begin
                since_q <= since_q + 4'h1;
            end
        end
    end

    // ************************************************************
    // receive framing
    // ************************************************************
    mcl_fr_e    fr_st_q;
    logic [6:0] wait_q;
    logic       prev_ok_q;
    logic       prev_bit_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fr_st_q    <= MCL_FR_WAIT;
            wait_q     <= 7'h0;
            prev_ok_q  <= 1'b0;
            prev_bit_q <= 1'b0;
        end else if (!line_activity_flag_o) begin
            fr_st_q   <= MCL_FR_WAIT;
            prev_ok_q <= 1'b0;
            wait_q    <= WAIT_LOAD;
        end else begin
            case (fr_st_q)
                MCL_FR_WAIT: begin
                    fr_st_q <= MCL_FR_HOLD;
                    wait_q  <= WAIT_LOAD - 7'h1;
                end
                MCL_FR_HOLD: begin
                    // bits decoded while holding never reach the hunt
                    if (wait_q == 7'h0) begin
                        fr_st_q <= MCL_FR_HUNT;
                    end else begin
                        wait_q <= wait_q - 7'h1;
                    end
                end
                MCL_FR_HUNT: begin
                    if (dec_stb_q) begin
                        prev_ok_q  <= 1'b1;
                        prev_bit_q <= dec_bit_q;
                        if (prev_ok_q && prev_bit_q && dec_bit_q) begin
                            fr_st_q <= MCL_FR_PASS;
                        end else if (prev_ok_q && !prev_bit_q && !dec_bit_q) begin
                            fr_st_q <= MCL_FR_DROP;
                        end
                    end
                end
                MCL_FR_PASS: begin
                    fr_st_q <= MCL_FR_PASS;
                end
                MCL_FR_DROP: begin
                    fr_st_q <= MCL_FR_DROP;
                end
                default: begin
                    fr_st_q <= MCL_FR_WAIT;
                end
            endcase
        end
    end

    // ************************************************************
    // receive bit stream to the data link
    // ************************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_bit_o   <= '0;
            rx_frame_o <= 1'b0;
        end else begin
            // collision corrupts decoding; bits still flow, the link
            // is told through collision only while transmitting and drops them itself
            rx_frame_o    <= (fr_st_q == MCL_FR_PASS) && line_activity_flag_o;
            rx_bit_o.stb  <= dec_stb_q && (fr_st_q == MCL_FR_PASS) &&
                             line_activity_flag_o;
            rx_bit_o.data <= dec_bit_q;
        end
    end

endmodule

`default_nettype wire

// File: verification/mcl_channel_sva.sv
// Purpose: port-level checks of the manchester channel
// Assumes: one clk_i domain, sys_rst_i async active high
// Notes:   quiet counters bound the 160 ns release times
`timescale 1ns/1ps
`default_nettype none
module mcl_channel_sva (
    input wire logic                clk_i,                  // clock
    input wire logic                sys_rst_i,              // reset
    input wire logic                tx_valid_i,             // offer
    input wire logic                tx_data_i,              // bit
    input wire logic                tx_ready_o,             // room
    input wire logic                tx_line_o,              // tx pair
    input wire logic                tx_en_o,                // sending
    input wire logic                rx_line_i,              // rx pair
    input wire logic                col_pres_i,             // col pair
    input wire mcl_pkg::mcl_rxbit_s rx_bit_o,               // rx bit
    input wire logic                rx_frame_o,             // framing
    input wire logic                collision_indication_o, // col flag
    input wire logic                line_activity_flag_o    // activity
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // ********
    // helpers
    // ********
    logic       col_q, rx_q, line_q;
    logic [7:0] cq_q, aq_q, age_q;
    logic [3:0] run_q;
    // saturate so a long idle never wraps back under the limit
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            col_q <= 1'b0;
            rx_q  <= 1'b0;
            cq_q  <= 8'h00;
            aq_q  <= 8'h00;
        end else begin
            col_q <= col_pres_i;
            rx_q  <= rx_line_i;
            cq_q  <= (col_pres_i != col_q) ? 8'h00 : cq_q + {7'h0, cq_q != 8'hFF};
            aq_q  <= (col_pres_i != col_q || rx_line_i != rx_q) ? 8'h00
                   : aq_q + {7'h0, aq_q != 8'hFF};
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            age_q <= 8'h00;
        else if (!line_activity_flag_o)
            age_q <= 8'h00;
        else if (age_q != 8'hFF)
            age_q <= age_q + 8'h01;
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_q <= 1'b0;
            run_q  <= 4'h0;
        end else begin
            line_q <= tx_line_o;
            if (!tx_en_o)
                run_q <= 4'h0;
            else if (tx_line_o != line_q)
                run_q <= 4'h1;
            else if (run_q != 4'hF)
                run_q <= run_q + 4'h1;
        end
    end
    a_coll_gate: assert property (
        !tx_en_o && !$past(tx_en_o) |-> !collision_indication_o)
        else $error("collision flag while idle");
    a_coll_rise: assert property (
        $changed(col_pres_i) && tx_en_o |-> ##[1:20] (collision_indication_o || !tx_en_o))
        else $error("collision flag late");
    a_coll_fall: assert property (
        cq_q >= 8'h11 |-> !collision_indication_o)
        else $error("collision flag held");
    a_act_rise: assert property (
        $changed(rx_line_i) || $changed(col_pres_i) |-> ##[1:20] line_activity_flag_o)
        else $error("activity flag late");
    a_act_fall: assert property (
        aq_q >= 8'h11 |-> !line_activity_flag_o)
        else $error("activity flag held");
    a_cell_mid: assert property (
        tx_en_o |-> run_q <= 4'hA)
        else $error("no transition within a cell");
    a_idle_low: assert property (
        !tx_en_o |-> !tx_line_o)
        else $error("line not idle");
    a_bit_pulse: assert property (
        rx_bit_o.stb |-> rx_frame_o ##1 !rx_bit_o.stb)
        else $error("bit strobe outside frame");
    a_hunt_wait: assert property (
        rx_frame_o && line_activity_flag_o |-> age_q >= 8'h50)
        else $error("marker hunted too early");
    a_frame_drop: assert property (
        $fell(line_activity_flag_o) |-> ##2 !rx_frame_o)
        else $error("framing kept after activity");
    c_coll: cover property (collision_indication_o);
    c_bit: cover property (rx_bit_o.stb);
    c_cut: cover property ($fell(tx_en_o));
endmodule
bind mcl_channel mcl_channel_sva chk_u (
    .clk_i, .sys_rst_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .tx_line_o, .tx_en_o,
    .rx_line_i, .col_pres_i, .rx_bit_o, .rx_frame_o, .collision_indication_o,
    .line_activity_flag_o
);
`default_nettype wire

// File: verification/mcl_xcvr_model.sv
// Purpose: behavioural transceiver on the line side
// Assumes: the bench calls its tasks
// Notes:   line timing is free running, unrelated to clk_i
`timescale 1ns/1ps
`default_nettype none
module mcl_xcvr_model (
    input  wire logic tx_line_i,  // transmit pair
    output var  logic rx_line_o,  // receive pair
    output var  logic col_pres_o  // collision pair
);
    // ********
    // line side
    // ********
    initial begin
        rx_line_o  = 1'b0;
        col_pres_o = 1'b0;
    end
    // own sending comes back as cable activity
    always @(tx_line_i) rx_line_o <= #23 tx_line_i;
    // broken first cell on purpose, then 100 ns cells
    task automatic send(input logic [71:0] pat, input int n);
        int i;
        #2;
        rx_line_o = ~rx_line_o;
        #37;
        for (i = 71; i > 71 - n; i--) begin
            rx_line_o = ~pat[i];
            #50;
            rx_line_o = pat[i];
            #50;
        end
    endtask
    task automatic collide(input int n);
        int i;
        #2;
        for (i = 0; i < n; i++) begin
            col_pres_o = ~col_pres_o;
            #50;
        end
    endtask
endmodule
`default_nettype wire

// File: verification/test_mcl_channel.sv
// Purpose: self-checking bench for the manchester channel
// Assumes: transceiver model on the line side
// Notes:   transmit bits are offered MSB first
`timescale 1ns/1ps
`default_nettype none
module test_mcl_channel;
    import mcl_pkg::*;
    logic       clk_i      = 1'b0;
    logic       sys_rst_i  = 1'b1;
    logic       tx_valid_i = 1'b0;
    logic       tx_data_i  = 1'b0;
    logic       tx_ready_o, tx_line_o, tx_en_o, rx_line_i, col_pres_i;
    logic       rx_frame_o, collision_indication_o, line_activity_flag_o;
    mcl_rxbit_s rx_bit_o;
    int         n_fail  = 0;
    int         checked = 0;
    logic       q[$];
    always #5 clk_i = ~clk_i;
    mcl_channel dut_u (
        .clk_i, .sys_rst_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .tx_line_o, .tx_en_o,
        .rx_line_i, .col_pres_i, .rx_bit_o, .rx_frame_o, .collision_indication_o,
        .line_activity_flag_o
    );
    mcl_xcvr_model xcvr_u (
        .tx_line_i  (tx_line_o),
        .rx_line_o  (rx_line_i),
        .col_pres_o (col_pres_i)
    );
    // ********
    // helpers
    // ********
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic timeout();
        chk(1'b0, "timeout");
        final_report();
    endtask
    task automatic feed(input logic [7:0] d);
        int i;
        int w;
        @(posedge clk_i);
        for (i = 7; i >= 0; i--) begin
            tx_valid_i <= 1'b1;
            tx_data_i  <= d[i];
            w = 0;
            do begin
                @(negedge clk_i);
                w++;
                if (w > 900) timeout();
            end while (tx_ready_o !== 1'b1);
            @(posedge clk_i);
        end
        tx_valid_i <= 1'b0;
    endtask
    // samples each half cell away from its edges
    task automatic capture();
        int c;
        logic h1;
        q.delete();
        for (c = 0; tx_en_o !== 1'b1; c++) begin
            if (c > 50) timeout();
            @(negedge clk_i);
        end
        for (c = 0; c < 100; c++) begin
            repeat (2) @(negedge clk_i);
            if (tx_en_o !== 1'b1) break;
            h1 = tx_line_o;
            repeat (5) @(negedge clk_i);
            chk(tx_line_o === ~h1, "no mid-cell edge");
            if (c > 0) chk(line_activity_flag_o === 1'b1, "own send unsensed");
            q.push_back(tx_line_o);
            repeat (3) @(negedge clk_i);
        end
    endtask
    task automatic chk_tx(input logic [7:0] d);
        int i;
        int np;
        np = q.size() - 8;
        for (i = 0; i < q.size(); i++)
            chk(q[i] === (i < np ? PRE_PAT[63 - i] : d[7 - (i - np)]), "tx bit");
    endtask
    task automatic collect();
        int c;
        bit up;
        q.delete();
        up = 0;
        for (c = 0; c < 1500; c++) begin
            @(negedge clk_i);
            if (rx_bit_o.stb === 1'b1) begin
                q.push_back(rx_bit_o.data);
                chk(rx_frame_o === 1'b1, "bit outside frame");
            end
            if (line_activity_flag_o === 1'b1) up = 1;
            if (up && line_activity_flag_o === 1'b0) break;
        end
        if (c == 1500) timeout();
        chk(up, "no line activity");
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_tx();
        fork
            feed(8'hB4);
        join_none
        capture();
        chk(q.size() == 72, "tx length");
        chk_tx(8'hB4);
        $display("t_tx done");
    endtask
    task automatic t_coll();
        fork
            feed(8'h5A);
            begin
                repeat (100) @(posedge clk_i);
                xcvr_u.collide(8);
            end
        join_none
        capture();
        chk(q.size() > 8 && q.size() < 72, "preamble not cut");
        chk_tx(8'h5A);
        $display("t_coll done");
    endtask
    task automatic t_cidle();
        bit cs;
        bit as;
        cs = 0;
        as = 0;
        repeat (30) @(negedge clk_i);
        chk(line_activity_flag_o === 1'b0, "activity left over");
        fork
            xcvr_u.collide(6);
        join_none
        repeat (50) begin
            @(negedge clk_i);
            if (collision_indication_o !== 1'b0) cs = 1;
            if (line_activity_flag_o === 1'b1) as = 1;
        end
        chk(!cs, "collision flag while idle");
        chk(as, "collision unsensed");
        chk(line_activity_flag_o === 1'b0, "activity held");
        $display("t_cidle done");
    endtask
    task automatic t_drop();
        fork
            xcvr_u.send({64'hAAAA_03FF_0000_0000, 8'h00}, 32);
        join_none
        collect();
        chk(q.size() == 0, "dropped frame forwarded");
        $display("t_drop done");
    endtask
    task automatic t_rx();
        int i;
        logic [7:0] d = 8'hC5;
        fork
            xcvr_u.send({PRE_PAT[60:0], d, 3'h0}, 69);
        join_none
        collect();
        chk(q.size() == 8, "rx length");
        for (i = 0; i < q.size(); i++)
            chk(q[i] === d[7 - i], "rx bit");
        $display("t_rx done");
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        chk({tx_ready_o, tx_en_o, tx_line_o, rx_bit_o, rx_frame_o} === 6'h00, "reset");
        chk({collision_indication_o, line_activity_flag_o} === 2'h0, "reset");
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        t_tx();
        t_coll();
        t_cidle();
        t_drop();
        t_rx();
        final_report();
    end
endmodule
`default_nettype wire
